// *** hw/pecr_pkg.sv ***
// Purpose: shared constants for the extended port control register block
// Assumes: APB with 32-bit data, one aligned word per register except the second window register at 0x401
// Notes: offsets are byte addresses
package pecr_pkg;
	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [11:0] PECR_OFF_CTRL = 12'h000;
	localparam logic [11:0] PECR_OFF_THR = 12'h004;
	localparam logic [11:0] PECR_OFF_IRQ_STAT = 12'h008;
	localparam logic [11:0] PECR_OFF_IRQ_EN = 12'h00C;
	localparam logic [11:0] PECR_OFF_IRQ_CLR = 12'h010;
	localparam logic [11:0] PECR_OFF_CFG1 = 12'h014;
	localparam logic [11:0] PECR_OFF_CFG2 = 12'h018;
	localparam logic [11:0] PECR_OFF_STATUS = 12'h01C;
	// configuration-mode window, index of the two config registers
	localparam logic [11:0] PECR_OFF_CFGWIN = 12'h400;
	localparam logic [11:0] PECR_OFF_CFGWIN2 = 12'h401;
	// -----------------------------------------------------------------
	// control field layout
	// -----------------------------------------------------------------
	localparam int PECR_MODE_HI = 7;
	localparam int PECR_MODE_LO = 5;
	localparam int PECR_BIT_FAULT_EN_N = 4;
	localparam int PECR_BIT_DMA_EN = 3;
	localparam int PECR_BIT_SVC_MASK = 2;
	localparam int PECR_BIT_FULL = 1;
	localparam int PECR_BIT_EMPTY = 0;
	localparam logic [7:0] PECR_CTRL_RESET = 8'h15;
	localparam logic [7:0] PECR_CTRL_WMASK = 8'hFC;
	// interrupt status layout
	localparam int PECR_IRQ_FAULT = 0;
	localparam int PECR_IRQ_SVC = 1;
	localparam int PECR_IRQ_W = 2;
	localparam logic [7:0] PECR_CFG_RESET = 8'h00;
	localparam logic [7:0] PECR_THR_RESET = 8'h08;
	// -----------------------------------------------------------------
	// mode codes
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		PECR_MODE_STD = 3'h0,
		PECR_MODE_BIDIR = 3'h1,
		PECR_MODE_FIFO = 3'h2,
		PECR_MODE_ECP = 3'h3,
		PECR_MODE_EPP = 3'h4,
		PECR_MODE_RSVD = 3'h5,
		PECR_MODE_TEST = 3'h6,
		PECR_MODE_CFG = 3'h7
	} pecr_mode_t;
endpackage

// *** hw/pecr_sync.sv ***
// Purpose: two flip-flop synchroniser for a pin level
// Assumes: input asynchronous to clock
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module pecr_sync (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// level
	input wire logic pin_in,
	output logic pin_sync
);
	logic meta_q;
	logic sync_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end
	assign pin_sync = sync_q;
endmodule

// *** hw/pecr_svc.sv ***
// Purpose: service-interrupt condition select
// Assumes: occupancy and thresholds in bytes, same clock
// Notes: pure combinational pick of the serviced event
`timescale 1ns/100ps
module pecr_svc #(
	parameter int DEPTH_W = 5
) (
	// control
	input wire logic dma_en,
	input wire logic direction,
	input wire logic dma_tc,
	// fifo state
	input wire logic [DEPTH_W-1:0] free_cnt,
	input wire logic [DEPTH_W-1:0] fill_cnt,
	input wire logic [DEPTH_W-1:0] tx_free_threshold,
	input wire logic [DEPTH_W-1:0] rx_fill_threshold,
	// result
	output logic svc_event
);
	always_comb begin
		if (dma_en) begin
			svc_event = dma_tc;
		end else if (!direction) begin
			svc_event = (free_cnt >= tx_free_threshold);
		end else begin
			svc_event = (fill_cnt >= rx_fill_threshold);
		end
	end
endmodule

// *** hw/pecr_top.sv ***
// Purpose: extended port control register with APB slave and interrupts
// Assumes: fifo occupancy, terminal count and direction from port logic
// Notes: fault pin, dma terminal count and fifo level are the only external events
`timescale 1ns/100ps
// Notes on behaviour
// - bits 7..5 of the control register hold a read/write mode field.
// - mode 000 holds the fifo in reset.
// - mode 100 turns on the enhanced parallel port operation.
// - mode 110 keeps fifo access but never drives fifo bytes to the port.
// - mode 111 maps the two config registers at 0x400 and 0x401.
// - bit 4 low enables the fault falling-edge interrupt in ecp mode.
// - bit 3 gates every dma request.
// - bit 2 is set by hardware on a serviced event and cleared by software.
// - with dma on, terminal count sets the service mask.
// - dma off and forward, enough free fifo space sets the mask.
// - dma off and reverse, enough valid fifo bytes sets the mask.
// - a set mask blocks dma and service events; writing 1 raises nothing.
// - bit 1 reads 1 when the fifo is full.
// - bit 0 reads 1 when the fifo is empty.
module pecr_top
	import pecr_pkg::*;
#(
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// port side status
	input wire logic [$clog2(DEPTH+1)-1:0] fifo_fill,
	input wire logic direction,
	input wire logic dma_tc,
	input wire logic peripheral_error_n,
	// controls to port logic
	output logic [2:0] port_mode,
	output logic fifo_reset,
	output logic epp_active,
	output logic fifo_to_port_en,
	output logic port_lines_en,
	output logic dma_request_enable,
	output logic [7:0] port_config_first,
	output logic [7:0] port_config_second,
	// interrupt
	output logic irq
);
	localparam int CW = $clog2(DEPTH+1);

	// counts and thresholds are one byte wide at most
	if (DEPTH < 2 || DEPTH > 255) begin : g_depth_check
		$error("pecr_top: DEPTH out of range");
	end

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	logic [2:0] mode_q, mode_d;
	logic fault_en_n_q, fault_en_n_d;
	logic dma_en_q, dma_en_d;
	logic svc_q, svc_d;
	logic [7:0] thr_tx_q, thr_tx_d;
	logic [7:0] thr_rx_q, thr_rx_d;
	logic [7:0] cfg1_q, cfg1_d;
	logic [7:0] cfg2_q, cfg2_d;
	logic [PECR_IRQ_W-1:0] stat_q, stat_d;
	logic [PECR_IRQ_W-1:0] ien_q, ien_d;
	logic [31:0] rdata_q, rdata_d;
	logic ready_q, ready_d;
	logic err_q, err_d;
	logic fault_prev_q;
	logic irq_q;
	logic full_q, empty_q;

	logic fault_s;
	logic svc_event;
	logic fault_fall;
	logic access;
	logic wr;
	logic [CW-1:0] free_cnt;
	logic full_now, empty_now;
	logic cfg_mode;

	pecr_sync u_fault_sync (
		.clock(clock),
		.rst(rst),
		.pin_in(peripheral_error_n),
		.pin_sync(fault_s)
	);

	assign free_cnt = CW'(DEPTH) - fifo_fill;
	assign full_now = (fifo_fill >= CW'(DEPTH));
	assign empty_now = (fifo_fill == '0);

	pecr_svc #(
		.DEPTH_W(CW)
	) u_svc (
		.dma_en(dma_en_q),
		.direction(direction),
		.dma_tc(dma_tc),
		.free_cnt(free_cnt),
		.fill_cnt(fifo_fill),
		.tx_free_threshold(thr_tx_q[CW-1:0]),
		.rx_fill_threshold(thr_rx_q[CW-1:0]),
		.svc_event(svc_event)
	);

	// -----------------------------------------------------------------
	// apb decode
	// -----------------------------------------------------------------
	// first cycle of access phase; pready follows one cycle later
	assign access = psel && penable && !ready_q;
	assign wr = access && pwrite;
	assign cfg_mode = (mode_q == PECR_MODE_CFG);
	assign fault_fall = fault_prev_q && !fault_s;

	// -----------------------------------------------------------------
	// register next state
	// -----------------------------------------------------------------
	always_comb begin
		mode_d = mode_q;
		fault_en_n_d = fault_en_n_q;
		dma_en_d = dma_en_q;
		svc_d = svc_q;
		thr_tx_d = thr_tx_q;
		thr_rx_d = thr_rx_q;
		cfg1_d = cfg1_q;
		cfg2_d = cfg2_q;
		ien_d = ien_q;
		stat_d = stat_q;
		if (wr) begin
			case (paddr)
				PECR_OFF_CTRL: begin
					mode_d = pwdata[PECR_MODE_HI:PECR_MODE_LO];
					fault_en_n_d = pwdata[PECR_BIT_FAULT_EN_N];
					dma_en_d = pwdata[PECR_BIT_DMA_EN];
					svc_d = pwdata[PECR_BIT_SVC_MASK];
					// full and empty are not stored
				end
				PECR_OFF_THR: begin
					thr_tx_d = pwdata[7:0];
					thr_rx_d = pwdata[15:8];
				end
				PECR_OFF_IRQ_EN: begin
					ien_d = pwdata[PECR_IRQ_W-1:0];
				end
				PECR_OFF_IRQ_CLR: begin
					stat_d = stat_q & ~pwdata[PECR_IRQ_W-1:0];
				end
				PECR_OFF_CFG1, PECR_OFF_CFGWIN: begin
					if (paddr == PECR_OFF_CFG1 || cfg_mode) begin
						cfg1_d = pwdata[7:0];
					end
				end
				PECR_OFF_CFG2, PECR_OFF_CFGWIN2: begin
					if (paddr == PECR_OFF_CFG2 || cfg_mode) begin
						cfg2_d = pwdata[7:0];
					end
				end
				default: begin
				end
			endcase
		end
		// hardware set wins over a software clear in the same cycle
		if (!svc_q && svc_event) begin
			svc_d = 1'b1;
			stat_d[PECR_IRQ_SVC] = 1'b1;
		end
		// ecp mode only, enable bit active low
		if (fault_fall && !fault_en_n_q && mode_q == PECR_MODE_ECP) begin
			stat_d[PECR_IRQ_FAULT] = 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// apb answer
	// -----------------------------------------------------------------
	always_comb begin
		rdata_d = 32'h0000_0000;
		err_d = 1'b0;
		ready_d = access;
		if (access) begin
			case (paddr)
				PECR_OFF_CTRL: begin
					rdata_d[7:0] = {mode_q, fault_en_n_q, dma_en_q, svc_q,
						full_now, empty_now};
				end
				PECR_OFF_THR: begin
					rdata_d[15:0] = {thr_rx_q, thr_tx_q};
				end
				PECR_OFF_IRQ_STAT: begin
					rdata_d[PECR_IRQ_W-1:0] = stat_q;
				end
				PECR_OFF_IRQ_EN: begin
					rdata_d[PECR_IRQ_W-1:0] = ien_q;
				end
				PECR_OFF_IRQ_CLR: begin
				end
				PECR_OFF_CFG1: begin
					rdata_d[7:0] = cfg1_q;
				end
				PECR_OFF_CFG2: begin
					rdata_d[7:0] = cfg2_q;
				end
				PECR_OFF_STATUS: begin
					rdata_d[1:0] = {full_q, empty_q};
				end
				PECR_OFF_CFGWIN: begin
					// outside configuration mode this offset answers with pslverr
					if (cfg_mode) begin
						rdata_d[7:0] = cfg1_q;
					end else begin
						err_d = 1'b1;
					end
				end
				PECR_OFF_CFGWIN2: begin
					if (cfg_mode) begin
						rdata_d[7:0] = cfg2_q;
					end else begin
						err_d = 1'b1;
					end
				end
				default: begin
					err_d = 1'b1;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			mode_q <= PECR_CTRL_RESET[PECR_MODE_HI:PECR_MODE_LO];
			fault_en_n_q <= PECR_CTRL_RESET[PECR_BIT_FAULT_EN_N];
			dma_en_q <= PECR_CTRL_RESET[PECR_BIT_DMA_EN];
			svc_q <= PECR_CTRL_RESET[PECR_BIT_SVC_MASK];
			thr_tx_q <= PECR_THR_RESET;
			thr_rx_q <= PECR_THR_RESET;
			cfg1_q <= PECR_CFG_RESET;
			cfg2_q <= PECR_CFG_RESET;
			stat_q <= '0;
			ien_q <= '0;
			rdata_q <= 32'h0000_0000;
			ready_q <= 1'b0;
			err_q <= 1'b0;
			fault_prev_q <= 1'b1;
			irq_q <= 1'b0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			mode_q <= mode_d;
			fault_en_n_q <= fault_en_n_d;
			dma_en_q <= dma_en_d;
			svc_q <= svc_d;
			thr_tx_q <= thr_tx_d;
			thr_rx_q <= thr_rx_d;
			cfg1_q <= cfg1_d;
			cfg2_q <= cfg2_d;
			stat_q <= stat_d;
			ien_q <= ien_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q <= err_d;
			fault_prev_q <= fault_s;
			irq_q <= |(stat_d & ien_d);
			full_q <= full_now;
			empty_q <= empty_now;
		end
	end

	// -----------------------------------------------------------------
	// port controls, all registered
	// -----------------------------------------------------------------
	logic [2:0] pmode_q;
	logic fifo_rst_q, epp_q, f2p_q, lines_q, dreq_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			pmode_q <= PECR_MODE_STD;
			fifo_rst_q <= 1'b1;
			epp_q <= 1'b0;
			f2p_q <= 1'b0;
			lines_q <= 1'b1;
			dreq_q <= 1'b0;
		end else begin
			pmode_q <= mode_d;
			fifo_rst_q <= (mode_d == PECR_MODE_STD) ||
				(mode_d == PECR_MODE_RSVD);
			epp_q <= (mode_d == PECR_MODE_EPP);
			// test mode keeps the fifo off the port lines
			f2p_q <= (mode_d == PECR_MODE_FIFO) ||
				(mode_d == PECR_MODE_ECP);
			lines_q <= (mode_d != PECR_MODE_RSVD);
			dreq_q <= dma_en_d && !svc_d;
		end
	end

	assign port_mode = pmode_q;
	assign fifo_reset = fifo_rst_q;
	assign epp_active = epp_q;
	assign fifo_to_port_en = f2p_q;
	assign port_lines_en = lines_q;
	assign dma_request_enable = dreq_q;
	assign port_config_first = cfg1_q;
	assign port_config_second = cfg2_q;
	assign irq = irq_q;
	assign prdata = rdata_q;
	assign pready = ready_q;
	assign pslverr = err_q;
endmodule

// *** bench/pecr_top_assertions.sv ***
// Purpose: port checks on the control register block
// Assumes: one clock, synchronous reset
// Notes: bound to pecr_top below
`timescale 1ns/100ps
module pecr_top_assertions
	import pecr_pkg::*;
#(
	parameter int DEPTH = 16
) (
	// apb
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// port side
	input wire logic [$clog2(DEPTH+1)-1:0] fifo_fill,
	input wire logic dma_tc,
	input wire logic [2:0] port_mode,
	input wire logic fifo_reset,
	input wire logic epp_active,
	input wire logic fifo_to_port_en,
	input wire logic dma_request_enable
);
	logic take;
	assign take = psel && penable && !pready;
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (rst);
	property p_answer;
		take |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pready too long");
	property p_mode;
		take && pwrite && paddr == PECR_OFF_CTRL |=> port_mode == pwdata[7:5];
	endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_std;
		port_mode == 3'h0 && $stable(port_mode) |-> fifo_reset;
	endproperty
	a_std: assert property (p_std) else $error("fifo reset");
	property p_epp;
		$stable(port_mode) |-> epp_active == (port_mode == 3'h4);
	endproperty
	a_epp: assert property (p_epp) else $error("epp");
	property p_test;
		port_mode == 3'h6 && $stable(port_mode) |->
			!fifo_to_port_en && !fifo_reset;
	endproperty
	a_test: assert property (p_test) else $error("test mode");
	property p_win;
		take && paddr == PECR_OFF_CFGWIN |=> pslverr == (port_mode != 3'h7);
	endproperty
	a_win: assert property (p_win) else $error("window");
	property p_tc;
		dma_tc && dma_request_enable && !psel |=> ##[0:1] !dma_request_enable;
	endproperty
	a_tc: assert property (p_tc) else $error("tc");
	property p_flags;
		take && !pwrite && paddr == PECR_OFF_CTRL |=>
			prdata[1:0] == {$past(fifo_fill) == DEPTH, $past(fifo_fill) == 0};
	endproperty
	a_flags: assert property (p_flags) else $error("flags");
endmodule
bind pecr_top pecr_top_assertions #(.DEPTH(DEPTH)) i_pecr_top_assertions (
	.clock(clock), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .fifo_fill(fifo_fill),
	.dma_tc(dma_tc), .port_mode(port_mode), .fifo_reset(fifo_reset),
	.epp_active(epp_active), .fifo_to_port_en(fifo_to_port_en),
	.dma_request_enable(dma_request_enable)
);

// *** bench/pecr_port_model.sv ***
// Purpose: port side stand-in for fifo level, dma and fault pin
// Assumes: bench changes commands just after a clock edge
// Notes: fault pin idles high like a pulled-up line
`timescale 1ns/100ps
module pecr_port_model (
	// commands
	input wire logic clock,
	input wire logic [4:0] fill_cmd,
	input wire logic dir_cmd,
	input wire logic tc_cmd,
	input wire logic fault_cmd,
	// port side
	output logic [4:0] fifo_fill,
	output logic direction,
	output logic dma_tc,
	output logic peripheral_error_n
);
	always_ff @(posedge clock) begin
		fifo_fill <= fill_cmd;
		direction <= dir_cmd;
		dma_tc <= tc_cmd;
		peripheral_error_n <= !fault_cmd;
	end
endmodule

// *** bench/testbench.sv ***
// Purpose: register level bench for the control block
// Assumes: DEPTH 16, apb slave with one wait state
// Notes: software side keeps the mode switching order
`timescale 1ns/100ps
module testbench
	import pecr_pkg::*;
;
	logic clock, rst, psel, penable, pwrite, pready, pslverr, e, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic direction, dma_tc, flt_n, dir_c, tc_c, flt_c;
	logic [2:0] port_mode;
	logic fifo_reset, epp_active, fifo_to_port_en, port_lines_en, dre;
	logic [4:0] fill, fill_c;
	logic [7:0] cfg_a, cfg_b;
	int n_fail, check_count;
	int fv[4] = '{0, 1, 15, 16};
	pecr_top #(.DEPTH(16)) i_pecr_top (.clock(clock), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fifo_fill(fill), .direction(direction),
		.dma_tc(dma_tc), .peripheral_error_n(flt_n),
		.port_mode(port_mode), .fifo_reset(fifo_reset),
		.epp_active(epp_active), .fifo_to_port_en(fifo_to_port_en),
		.port_lines_en(port_lines_en), .dma_request_enable(dre),
		.port_config_first(cfg_a), .port_config_second(cfg_b), .irq(irq));
	pecr_port_model i_pecr_port_model (.clock(clock), .fill_cmd(fill_c),
		.dir_cmd(dir_c), .tc_cmd(tc_c), .fault_cmd(flt_c),
		.fifo_fill(fill), .direction(direction), .dma_tc(dma_tc),
		.peripheral_error_n(flt_n));
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, y);
		check_count++;
		if (x !== y) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, x, y);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 9);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_fail++;
			complete_run();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk("read", x, r);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// bounded wait, then compare the level
	task automatic wait_irq(input logic v);
		int k;
		k = 0;
		while (irq !== v && k < 20) begin
			@(posedge clock);
			k++;
		end
		chk("irq", v, irq);
		// a wait that ran out ends the run
		if (irq !== v) begin
			complete_run();
		end
	endtask
	task automatic fault;
		@(posedge clock);
		flt_c <= 1'b1;
		repeat (3) @(posedge clock);
		flt_c <= 1'b0;
	endtask
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		{rst, psel, penable, pwrite, dir_c, tc_c, flt_c} = 7'h40;
		paddr = 12'h0;
		pwdata = 32'h0;
		fill_c = 5'h0;
		n_fail = 0;
		check_count = 0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		rd(PECR_OFF_CTRL, 32'h15);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped", 1, e);
		$display("test reset done");
		for (int m = 0; m < 8; m++) begin
			wr(PECR_OFF_CTRL, {24'h0, m[2:0], 5'h14});
			@(negedge clock);
			chk("mode", m, port_mode);
			chk("epp", m == 4, epp_active);
			chk("to port", m == 2 || m == 3, fifo_to_port_en);
			chk("fifo rst", m == 0 || m == 5, fifo_reset);
			chk("lines", m != 5, port_lines_en);
			apb(1'b0, PECR_OFF_CFGWIN, 32'h0);
			chk("window", m != 7, e);
			wr(PECR_OFF_CTRL, 32'h14);
		end
		wr(PECR_OFF_CFG1, 32'hA5);
		wr(PECR_OFF_CTRL, 32'hF4);
		wr(PECR_OFF_CFGWIN2, 32'h5A);
		rd(PECR_OFF_CFGWIN, 32'hA5);
		chk("window ok", 0, e);
		@(negedge clock);
		chk("config", 32'h5AA5, {cfg_b, cfg_a});
		wr(PECR_OFF_CTRL, 32'h14);
		$display("test modes done");
		foreach (fv[i]) begin
			fill_c <= fv[i][4:0];
			wr(PECR_OFF_CTRL, 32'h17);
			rd(PECR_OFF_CTRL, {30'h5, fv[i] == 16, fv[i] == 0});
			rd(PECR_OFF_STATUS, {30'h0, fv[i] == 16, fv[i] == 0});
		end
		$display("test flags done");
		fill_c <= 5'd14;
		wr(PECR_OFF_THR, 32'h0804);
		wr(PECR_OFF_IRQ_EN, 32'h3);
		wr(PECR_OFF_CTRL, 32'h50);
		rd(PECR_OFF_CTRL, 32'h50);
		fill_c <= 5'd12;
		wait_irq(1'b1);
		rd(PECR_OFF_CTRL, 32'h54);
		wr(PECR_OFF_IRQ_CLR, 32'h2);
		wait_irq(1'b0);
		fill_c <= 5'd14;
		wr(PECR_OFF_CTRL, 32'h50);
		wr(PECR_OFF_CTRL, 32'h54);
		rd(PECR_OFF_IRQ_STAT, 32'h0);
		wr(PECR_OFF_CTRL, 32'h14);
		dir_c <= 1'b1;
		fill_c <= 5'd7;
		wr(PECR_OFF_CTRL, 32'h70);
		rd(PECR_OFF_CTRL, 32'h70);
		fill_c <= 5'd8;
		wait_irq(1'b1);
		wr(PECR_OFF_IRQ_CLR, 32'h2);
		fill_c <= 5'd7;
		wr(PECR_OFF_CTRL, 32'h78);
		@(negedge clock);
		chk("dma on", 1, dre);
		@(posedge clock);
		tc_c <= 1'b1;
		@(posedge clock);
		tc_c <= 1'b0;
		wait_irq(1'b1);
		chk("dma off", 0, dre);
		rd(PECR_OFF_CTRL, 32'h7C);
		wr(PECR_OFF_CTRL, 32'h70);
		@(negedge clock);
		chk("dma gate", 0, dre);
		$display("test service done");
		wr(PECR_OFF_CTRL, 32'h14);
		wr(PECR_OFF_IRQ_CLR, 32'h3);
		wr(PECR_OFF_CTRL, 32'h64);
		fault();
		wait_irq(1'b1);
		rd(PECR_OFF_IRQ_STAT, 32'h1);
		wr(PECR_OFF_IRQ_CLR, 32'h1);
		wr(PECR_OFF_CTRL, 32'h74);
		fault();
		repeat (8) @(posedge clock);
		rd(PECR_OFF_IRQ_STAT, 32'h0);
		$display("test fault done");
		complete_run();
	end
endmodule
